//--- hw/sdwp_top.sv
// Serial write port of a 12-bit converter with APB status and control
`timescale 1ns/1ns
`include "sdwp_defines.svh"

// Summary of operation
// - Shift data in on falling serial edges
// - Sixteenth falling edge executes the frame
// - Select held low or raised: both complete
// - Select falling edge starts a new frame
// - First two bits ignored, next two mode
// - Data sent most significant bit first
// - Early select rise discards the frame
// - Code register clears to zero at reset
// - Mode decode: normal, 1k, 100k, hi-z
// - Power-down frames still load the code register
// - Code is unsigned straight binary twelve bits
module sdwp_top #(
    parameter int WAKE_CYCLES = `SDWP_WAKEUP_CYCLES,
    parameter int COUNT_BITS = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clk,
    input wire logic frame_sel_n,
    input wire logic serial_din,
    output logic [11:0] dac_code,
    output logic [1:0] dac_mode,
    output logic power_down,
    output logic out_pulldown_1k,
    output logic out_pulldown_100k,
    output logic out_hiz,
    output logic wakeup_done
);

    // Wake counter is 16 bits, frame count is read back in one word
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535)
    begin : g_bad_wake
        $error("WAKE_CYCLES out of range");
    end
    if (COUNT_BITS < 1 || COUNT_BITS > 32)
    begin : g_bad_count
        $error("COUNT_BITS out of range");
    end

    // ---------------- Link domain (falling serial clock) ----------------

    logic [14:0] shift_r;
    logic [4:0] bit_cnt_r;
    logic [13:0] word_r;
    logic frame_tgl_r;
    logic [15:0] full_word;
    logic last_edge;
    logic frame_clr;

    // Select high or bus reset ends any frame in progress
    assign frame_clr = frame_sel_n | ~presetn;
    assign full_word = {shift_r, serial_din};
    assign last_edge = (bit_cnt_r == 5'(`SDWP_FRAME_BITS - 1));

    always_ff @(negedge serial_clk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            shift_r <= 15'h0000;
            bit_cnt_r <= 5'h00;
        end
        else if (bit_cnt_r != 5'(`SDWP_FRAME_BITS))
        begin
            shift_r <= full_word[14:0];
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // Extra edges after the sixteenth with select low change nothing
    always_ff @(negedge serial_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_r <= 14'h0000;
            frame_tgl_r <= 1'b0;
        end
        else if (last_edge && !frame_sel_n)
        begin
            word_r <= full_word[13:0];
            frame_tgl_r <= ~frame_tgl_r;
        end
    end

    // ---------------- Bus clock domain ----------------

    logic tgl_sync;
    logic tgl_seen_r;
    logic new_frame;

    sdwp_sync #(
        .WIDTH(1)
    ) u_tgl_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(frame_tgl_r),
        .q(tgl_sync)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tgl_seen_r <= 1'b0;
        else
            tgl_seen_r <= tgl_sync;
    end

    assign new_frame = tgl_sync ^ tgl_seen_r;

    // Control register
    logic apply_en_r;
    logic [COUNT_BITS-1:0] frames_r;
    logic [COUNT_BITS-1:0] frames_nxt;

    // Converter state
    logic [11:0] code_r;
    logic [1:0] mode_r;
    logic load;
    logic [11:0] code_nxt;
    sdwp_pkg::sdwp_mode_type mode_nxt;

    // Word held stable in link domain until next sixteen edges
    assign load = new_frame & apply_en_r;
    assign code_nxt = word_r[`SDWP_CODE_MSB:0];
    assign mode_nxt = sdwp_pkg::sdwp_mode_type'(
        {word_r[`SDWP_MODE_HI_POS], word_r[`SDWP_MODE_LO_POS]});

    function automatic logic [3:0] mode_decode(input logic [1:0] m);
        // {power_down, pulldown_1k, pulldown_100k, hiz}
        case (sdwp_pkg::sdwp_mode_type'(m))
            sdwp_pkg::SDWP_MODE_NORMAL: mode_decode = 4'h0;
            sdwp_pkg::SDWP_MODE_PD_1K: mode_decode = 4'hC;
            sdwp_pkg::SDWP_MODE_PD_100K: mode_decode = 4'hA;
            sdwp_pkg::SDWP_MODE_PD_HIZ: mode_decode = 4'h9;
            default: mode_decode = 4'h0;
        endcase
    endfunction

    logic [3:0] out_flags;
    assign out_flags = mode_decode(mode_nxt);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code_r <= `SDWP_CODE_RESET;
            mode_r <= `SDWP_MODE_RESET;
            dac_code <= `SDWP_CODE_RESET;
            dac_mode <= `SDWP_MODE_RESET;
            {power_down, out_pulldown_1k, out_pulldown_100k, out_hiz} <= 4'h0;
        end
        else if (load)
        begin
            // Code always loads, power-down or not
            code_r <= code_nxt;
            mode_r <= mode_nxt;
            dac_code <= code_nxt;
            dac_mode <= mode_nxt;
            {power_down, out_pulldown_1k, out_pulldown_100k, out_hiz} <= out_flags;
        end
    end

    // ---------------- Wake-up tracker ----------------

    sdwp_pkg::sdwp_wake_type wake_r;
    sdwp_pkg::sdwp_wake_type wake_nxt;
    logic [15:0] wake_cnt_r;
    logic [15:0] wake_cnt_nxt;
    logic going_normal;
    logic going_down;

    assign going_normal = load && (mode_nxt == sdwp_pkg::SDWP_MODE_NORMAL);
    assign going_down = load && (mode_nxt != sdwp_pkg::SDWP_MODE_NORMAL);

    always_comb
    begin
        wake_nxt = wake_r;
        wake_cnt_nxt = wake_cnt_r;
        case (wake_r)
            sdwp_pkg::SDWP_WAKE_ASLEEP:
            begin
                if (going_normal)
                begin
                    wake_nxt = sdwp_pkg::SDWP_WAKE_WAKING;
                    wake_cnt_nxt = 16'(WAKE_CYCLES - 1);
                end
            end
            sdwp_pkg::SDWP_WAKE_WAKING:
            begin
                if (going_down)
                    wake_nxt = sdwp_pkg::SDWP_WAKE_ASLEEP;
                else if (wake_cnt_r == 16'h0000)
                    wake_nxt = sdwp_pkg::SDWP_WAKE_AWAKE;
                else
                    wake_cnt_nxt = wake_cnt_r - 16'h0001;
            end
            sdwp_pkg::SDWP_WAKE_AWAKE:
            begin
                if (going_down)
                    wake_nxt = sdwp_pkg::SDWP_WAKE_ASLEEP;
            end
            default:
            begin
                wake_nxt = sdwp_pkg::SDWP_WAKE_AWAKE;
                wake_cnt_nxt = 16'h0000;
            end
        endcase
    end

    // Reset powers up in normal mode at zero code
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_r <= sdwp_pkg::SDWP_WAKE_AWAKE;
            wake_cnt_r <= 16'h0000;
            wakeup_done <= 1'b1;
        end
        else
        begin
            wake_r <= wake_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            wakeup_done <= (wake_nxt == sdwp_pkg::SDWP_WAKE_AWAKE);
        end
    end

    // ---------------- APB slave ----------------

    logic setup;
    logic access;
    logic wr_en;
    logic hit_ctrl;
    logic hit_status;
    logic hit_frames;
    logic hit_any;
    logic clr_cnt;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr_en = access & pwrite;
    assign hit_ctrl = (paddr == `SDWP_CTRL_OFFSET);
    assign hit_status = (paddr == `SDWP_STATUS_OFFSET);
    assign hit_frames = (paddr == `SDWP_FRAMES_OFFSET);
    assign hit_any = hit_ctrl | hit_status | hit_frames;
    assign clr_cnt = wr_en & hit_ctrl & pwdata[`SDWP_CTRL_CLRCNT_POS];

    assign status_word = (32'(code_r) << `SDWP_STAT_CODE_LSB)
        | (32'(mode_r) << `SDWP_STAT_MODE_LSB)
        | (32'(wakeup_done) << `SDWP_STAT_READY_POS)
        | (32'(wake_r == sdwp_pkg::SDWP_WAKE_WAKING) << `SDWP_STAT_WAKING_POS);

    assign rd_mux = hit_ctrl ? (32'(apply_en_r) << `SDWP_CTRL_APPLY_POS) :
        hit_status ? status_word :
        hit_frames ? 32'(frames_r) : 32'h0000_0000;

    // A frame arriving with a clear still counts
    assign frames_nxt = new_frame ? (clr_cnt ? COUNT_BITS'(1) : frames_r + COUNT_BITS'(1)) :
        (clr_cnt ? '0 : frames_r);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apply_en_r <= 1'(`SDWP_CTRL_RESET >> `SDWP_CTRL_APPLY_POS);
            frames_r <= '0;
        end
        else
        begin
            if (wr_en && hit_ctrl)
                apply_en_r <= pwdata[`SDWP_CTRL_APPLY_POS];
            frames_r <= frames_nxt;
        end
    end

    // One wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~hit_any;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

endmodule // sdwp_top

//--- hw/sdwp_defines.svh
// Offsets, field positions, reset values and timing counts of the serial converter write port
`ifndef SDWP_DEFINES_SVH
`define SDWP_DEFINES_SVH

// Serial frame layout
`define SDWP_FRAME_BITS 16
`define SDWP_CODE_BITS 12
`define SDWP_MODE_HI_POS 13
`define SDWP_MODE_LO_POS 12
`define SDWP_CODE_MSB 11
`define SDWP_CODE_RESET 12'h000
`define SDWP_MODE_RESET 2'h0

// APB register byte offsets
`define SDWP_CTRL_OFFSET 12'h000
`define SDWP_STATUS_OFFSET 12'h004
`define SDWP_FRAMES_OFFSET 12'h008

// CTRL fields
`define SDWP_CTRL_APPLY_POS 0
`define SDWP_CTRL_CLRCNT_POS 1
`define SDWP_CTRL_RESET 32'h0000_0001

// STATUS fields
`define SDWP_STAT_CODE_LSB 0
`define SDWP_STAT_MODE_LSB 12
`define SDWP_STAT_READY_POS 16
`define SDWP_STAT_WAKING_POS 17

// Wake-up time and bus clock
`define SDWP_WAKEUP_NS 6000
`define SDWP_PCLK_PERIOD_NS 10
`define SDWP_WAKEUP_CYCLES ((`SDWP_WAKEUP_NS + `SDWP_PCLK_PERIOD_NS - 1) / `SDWP_PCLK_PERIOD_NS)

`endif

//--- hw/sdwp_pkg.sv
// Types of the serial converter write port
package sdwp_pkg;

    typedef enum logic [1:0] {
        SDWP_MODE_NORMAL = 2'h0,
        SDWP_MODE_PD_1K = 2'h1,
        SDWP_MODE_PD_100K = 2'h2,
        SDWP_MODE_PD_HIZ = 2'h3
    } sdwp_mode_type;

    typedef enum logic [2:0] {
        SDWP_WAKE_ASLEEP = 3'h1,
        SDWP_WAKE_WAKING = 3'h2,
        SDWP_WAKE_AWAKE = 3'h4
    } sdwp_wake_type;

endpackage

//--- hw/sdwp_sync.sv
// Two-flop synchroniser for levels entering the bus clock domain
`timescale 1ns/1ns
module sdwp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sdwp_sync

//--- tb/sdwp_host_model.sv
// Serial host model driving frames into the converter write port
`timescale 1ns/1ns
module sdwp_host_model (
    output logic serial_clk,
    output logic frame_sel_n,
    output logic serial_din
);
    initial
    begin
        serial_clk = 1'b0;
        frame_sel_n = 1'b1;
        serial_din = 1'b0;
    end
    task start_frame();
        frame_sel_n = 1'b1;
        #43;
        frame_sel_n = 1'b0;
        #10;
    endtask
    // Clock stands low outside frames
    task shift(input logic [15:0] w, input int n);
        for (int i = 0; i < n; i++)
        begin
            #16 serial_clk = 1'b1;
            serial_din = w[15 - i];
            #16 serial_clk = 1'b0;
        end
    endtask
    task end_frame();
        #10 frame_sel_n = 1'b1;
        serial_din = ~serial_din;
        #40;
        frame_sel_n = 1'b0;
        serial_din = 1'b0;
    endtask
endmodule // sdwp_host_model

//--- tb/sdwp_top_monitor.sv
// Concurrent checks on the ports of the converter write port
`timescale 1ns/1ns
module sdwp_top_monitor #(
    parameter int WAKE_CYCLES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] dac_mode,
    input wire logic power_down,
    input wire logic out_pulldown_1k,
    input wire logic out_pulldown_100k,
    input wire logic out_hiz,
    input wire logic wakeup_done
);
    localparam int WAKE_MAX = WAKE_CYCLES + 4;
    wire logic mapped;
    assign mapped = (paddr == 12'h000) || (paddr == 12'h004) || (paddr == 12'h008);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    chk_pd_flag: assert property (power_down == (dac_mode != 2'h0))
        else $error("power_down wrong");
    chk_pull_1k: assert property (out_pulldown_1k == (dac_mode == 2'h1))
        else $error("1k flag wrong");
    chk_pull_100k: assert property (out_pulldown_100k == (dac_mode == 2'h2))
        else $error("100k flag wrong");
    chk_hiz_flag: assert property (out_hiz == (dac_mode == 2'h3))
        else $error("hiz flag wrong");
    chk_pd_asleep: assert property (power_down |-> !wakeup_done)
        else $error("awake in power-down");
    chk_wake_early: assert property ($fell(power_down) |-> !wakeup_done [*4])
        else $error("wake too early");
    chk_wake_late: assert property ($fell(power_down) |-> ##[0:WAKE_MAX] wakeup_done)
        else $error("wake too late");
    cover property (pslverr);
    cover property ($fell(power_down));
    cover property (out_hiz);
endmodule // sdwp_top_monitor
bind sdwp_top sdwp_top_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_sdwp_top_monitor (.pclk, .presetn,
    .psel, .penable, .paddr, .prdata, .pready, .pslverr, .dac_mode, .power_down,
    .out_pulldown_1k, .out_pulldown_100k, .out_hiz, .wakeup_done);

//--- tb/sdwp_top_tb.sv
// Testbench of the converter write port
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module sdwp_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr, dac_code;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] dac_mode;
    logic power_down, out_pulldown_1k, out_pulldown_100k, out_hiz, wakeup_done;
    wire logic serial_clk, frame_sel_n, serial_din;
    int err_total, n_checks;
    sdwp_top #(.WAKE_CYCLES(8)) u_sdwp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .serial_clk, .frame_sel_n, .serial_din, .dac_code,
        .dac_mode, .power_down, .out_pulldown_1k, .out_pulldown_100k, .out_hiz, .wakeup_done);
    sdwp_host_model u_sdwp_host_model (.serial_clk, .frame_sel_n, .serial_din);
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task stop_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge pclk);
        if (k == 20)
        begin
            err_total++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task settle();
        repeat (6) @(posedge pclk);
    endtask
    task frame(input logic [15:0] w);
        u_sdwp_host_model.start_frame();
        u_sdwp_host_model.shift(w, 16);
        u_sdwp_host_model.end_frame();
        settle();
    endtask
    task status(input logic [11:0] c, input logic [1:0] m);
        apb(1'b0, 12'h004, 32'h0);
        `CHK("code", c, rd[11:0])
        `CHK("mode", m, rd[13:12])
        `CHK("dac_code", c, dac_code)
        `CHK("dac_mode", m, dac_mode)
    endtask
    task frames(input logic [31:0] n);
        apb(1'b0, 12'h008, 32'h0);
        `CHK("frames", n, rd)
    endtask
    task s_reset();
        status(12'h000, 2'h0);
        `CHK("rst_ready", 2'h1, rd[17:16])
        `CHK("wake", 1'b1, wakeup_done)
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl", 32'h0000_0001, rd)
        frames(32'h0);
    endtask
    task s_normal();
        frame(16'hCA5C);
        status(12'hA5C, 2'h0);
        frame(16'h0FFF);
        status(12'hFFF, 2'h0);
    endtask
    task s_abort();
        u_sdwp_host_model.start_frame();
        u_sdwp_host_model.shift(16'h1123, 10);
        u_sdwp_host_model.end_frame();
        settle();
        status(12'hFFF, 2'h0);
        frames(32'h2);
    endtask
    task s_bytes();
        u_sdwp_host_model.start_frame();
        u_sdwp_host_model.shift(16'h0300, 8);
        repeat (3) @(posedge pclk);
        u_sdwp_host_model.shift(16'h2100, 8);
        u_sdwp_host_model.end_frame();
        settle();
        status(12'h321, 2'h0);
    endtask
    task s_held();
        u_sdwp_host_model.start_frame();
        u_sdwp_host_model.shift(16'h0456, 16);
        settle();
        status(12'h456, 2'h0);
        u_sdwp_host_model.shift(16'hC000, 2);
        u_sdwp_host_model.end_frame();
        settle();
        status(12'h456, 2'h0);
    endtask
    task s_pdown();
        int k;
        for (int m = 1; m < 4; m++)
        begin
            frame(16'h0456 | 16'(m << 12));
            status(12'h456, 2'(m));
            `CHK("asleep", 2'h0, rd[17:16])
            `CHK("pd1k", m == 1, out_pulldown_1k)
            `CHK("pd100k", m == 2, out_pulldown_100k)
            `CHK("hiz", m == 3, out_hiz)
        end
        frame(16'h0456);
        for (k = 0; k < 40 && wakeup_done !== 1'b1; k++)
            @(posedge pclk);
        `CHK("wake", 1'b1, wakeup_done)
        status(12'h456, 2'h0);
        `CHK("awake", 2'h1, rd[17:16])
    endtask
    task s_apb();
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("slverr", 1'b1, er)
        `CHK("rdata", 32'h0, rd)
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        apb(1'b1, 12'h000, 32'h0);
        frame(16'h0777);
        status(12'h456, 2'h0);
        frames(32'h9);
        apb(1'b1, 12'h000, 32'h3);
        frames(32'h0);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl", 32'h0000_0001, rd)
    endtask
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_total = 0;
        n_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset();
        s_normal();
        s_abort();
        s_bytes();
        s_held();
        s_pdown();
        s_apb();
        stop_test();
    end
endmodule // sdwp_top_tb
